// >>> bench/dtbi_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module dtbi_ctrl_model (
  input  wire logic       ref_clk_i,
  input  wire logic       go_i,
  input  wire logic       bad_i,
  input  wire logic [3:0] tag_i,
  input  wire logic [7:0] obus_i,
  output logic            tag_gate_o,
  output logic [3:0]      tag_bus_o,
  output logic            tag_par_o,
  output logic [7:0]      obus_o,
  output logic            obus_par_o
);
  initial
  begin
    {tag_gate_o, tag_bus_o, tag_par_o, obus_o, obus_par_o} = '0;
  end
  // released tag, bus and parity lines toggle each cycle; tag gate stays low
  always @(negedge ref_clk_i)
  begin
    tag_gate_o <= go_i;
    tag_bus_o  <= go_i ? tag_i : ~tag_bus_o;
    tag_par_o  <= go_i ? ~^tag_i ^ bad_i : ~tag_par_o;
    obus_o     <= go_i ? obus_i : ~obus_o;
    obus_par_o <= go_i ? ~^obus_i : ~obus_par_o;
  end
endmodule : dtbi_ctrl_model
`default_nettype wire

// >>> bench/dtbi_props.sv
`timescale 1ns/10ps
`default_nettype none
module dtbi_props (
  input wire logic       ref_clk_i,
  input wire logic       rstn_i,
  input wire logic [3:0] tag_bus_i,
  input wire logic       tag_par_i,
  input wire logic       tag_gate_i,
  input wire logic [7:0] bus_out_i,
  input wire logic       bus_out_par_i,
  input wire logic       module_select_gate_i,
  input wire logic       controller_power_present_i,
  input wire logic       power_up_seq_n_i,
  input wire logic [2:0] logical_unit_number_setting_i,
  input wire logic       selected_o,
  input wire logic [5:0] sel_code_o,
  input wire logic [7:0] inbound_status_bus_o,
  input wire logic       inbound_par_o,
  input wire logic       tag_valid_o,
  input wire logic       power_seq_start_o
);
  wire logic tag_ok = tag_gate_i && controller_power_present_i && ^{tag_bus_i, tag_par_i};
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_sel;
    tag_ok && tag_bus_i == 4'h3 && module_select_gate_i && ^{bus_out_i, bus_out_par_i}
      && bus_out_i[7:5] == logical_unit_number_setting_i
      ##1 module_select_gate_i && controller_power_present_i;
  endsequence
  sequence s_pulse;
    power_seq_start_o ##1 !power_seq_start_o;
  endsequence
  property p_tv; tag_ok |-> ##2 tag_valid_o; endproperty
  a_tv: assert property (p_tv) else $error("tag valid missing");
  property p_nval; !tag_ok |-> ##2 !tag_valid_o; endproperty
  a_nval: assert property (p_nval) else $error("tag valid unexpected");
  property p_sel; s_sel |-> ##1 selected_o; endproperty
  a_sel: assert property (p_sel) else $error("select missing");
  property p_drop; !module_select_gate_i |=> !selected_o; endproperty
  a_drop: assert property (p_drop) else $error("select held");
  property p_code; selected_o |-> $countones(sel_code_o) == 3; endproperty
  a_code: assert property (p_code) else $error("code not 3 of 6");
  property p_idle;
    !selected_o |-> sel_code_o == 6'h00 && inbound_status_bus_o == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("unselected lines busy");
  property p_par; inbound_par_o == ~^inbound_status_bus_o; endproperty
  a_par: assert property (p_par) else $error("inbound parity even");
  property p_pwr; $fell(power_up_seq_n_i) |-> ##[1:2] s_pulse; endproperty
  a_pwr: assert property (p_pwr) else $error("power start missing");
endmodule : dtbi_props
bind dtbi_top dtbi_props u_props (.*);
`default_nettype wire

// >>> bench/dtbi_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module dtbi_tb_top;
  import dtbi_pkg::*;
  localparam logic [5:0] code_tab [8] = '{6'h38, 6'h31, 6'h2a, 6'h23,
                                          6'h1c, 6'h15, 6'h0e, 6'h07};
  logic       clk, rstn, go, bad, msg, grst, cpwr, pup_n, is200, onl, seek, srch, sdone, rrdy;
  logic       resv, gate, tpar, opar, sel, ibp, tv, met, rsv, pss;
  logic [3:0] tag, tbus, atag;
  logic [7:0] obus, ob, stat, ib;
  logic [2:0] lun, loc;
  logic [5:0] sc;
  int         fails = 0;
  int         checked = 0;
  dtbi_ctrl_model ctrl (.ref_clk_i(clk), .go_i(go), .bad_i(bad), .tag_i(tag), .obus_i(obus),
    .tag_gate_o(gate), .tag_bus_o(tbus), .tag_par_o(tpar), .obus_o(ob), .obus_par_o(opar));
  dtbi_top dut (.ref_clk_i(clk), .rstn_i(rstn), .tag_bus_i(tbus), .tag_par_i(tpar),
    .tag_gate_i(gate), .bus_out_i(ob), .bus_out_par_i(opar), .module_select_gate_i(msg),
    .general_reset_i(grst), .controller_power_present_i(cpwr), .power_up_seq_n_i(pup_n),
    .logical_unit_number_setting_i(lun), .location_i(loc), .is_200mb_i(is200),
    .status_i(stat), .on_line_i(onl), .seek_busy_i(seek), .search_start_i(srch),
    .seek_done_irq_i(sdone), .record_ready_irq_i(rrdy), .reserve_set_i(resv),
    .selected_o(sel), .sel_code_o(sc), .inbound_status_bus_o(ib), .inbound_par_o(ibp),
    .tag_valid_o(tv), .metering_a_o(met), .reserved_o(rsv), .power_seq_start_o(pss),
    .active_tag_o(atag));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e)
    begin
      fails++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic send(input logic [3:0] t, input logic [7:0] o, input logic b);
    @(posedge clk);
    go <= 1'b1;
    tag <= t;
    obus <= o;
    bad <= b;
    cyc(3);
  endtask : send
  task automatic idle;
    @(posedge clk);
    go <= 1'b0;
    cyc(2);
  endtask : idle
  task automatic t_tags;
    for (int i = 0; i < 16; i++)
    begin
      send(4'(i), 8'h00, 1'b0);
      chk("tag_valid", 8'h01, 8'(tv));
      chk("active_tag", 8'(i), 8'(atag));
    end
    idle();
    send(4'h5, 8'h00, 1'b1);
    chk("bad_par", 8'h00, 8'(tv));
    idle();
    @(negedge clk) cpwr = 1'b0;
    send(4'h5, 8'h00, 1'b0);
    chk("no_power", 8'h00, 8'(tv));
    idle();
    @(negedge clk) cpwr = 1'b1;
  endtask : t_tags
  task automatic t_sel;
    for (int l = 0; l < 8; l++)
    begin
      @(negedge clk);
      loc = 3'(l);
      lun = 3'(7 - l);
      is200 = l[0];
      msg = 1'b1;
      send(4'h3, {lun, 5'h00}, 1'b0);
      chk("selected", 8'h01, 8'(sel));
      chk("sel_code", 8'(code_tab[l]), 8'(sc));
      chk("bit6", 8'(is200), 8'(ib[6]));
      chk("inbound", {stat[7], is200, stat[5:0]}, ib);
      chk("inbound_par", 8'(~^{stat[7], is200, stat[5:0]}), 8'(ibp));
      idle();
      @(negedge clk) msg = 1'b0;
      cyc(2);
      chk("dropped", 8'h00, 8'(sel));
      chk("idle_code", 8'h00, 8'(sc));
      chk("idle_bus", 8'h00, ib);
    end
    @(negedge clk) msg = 1'b1;
    send(4'h3, {~lun, 5'h00}, 1'b0);
    chk("wrong_addr", 8'h00, 8'(sel));
    send(4'h3, {lun, 5'h00}, 1'b1);
    chk("bad_par_sel", 8'h00, 8'(sel));
    idle();
  endtask : t_sel
  task automatic t_resv;
    send(4'h3, {lun, 5'h00}, 1'b0);
    @(negedge clk) resv = 1'b1;
    @(negedge clk) grst = 1'b1;
    resv = 1'b0;
    cyc(2);
    chk("kept", 8'h01, 8'(rsv));
    @(negedge clk) msg = 1'b0;
    cyc(3);
    chk("cleared", 8'h00, 8'(rsv));
    @(negedge clk) grst = 1'b0;
    idle();
  endtask : t_resv
  task automatic t_meter;
    @(negedge clk);
    onl = 1'b1;
    seek = 1'b1;
    msg = 1'b1;
    send(4'h3, {lun, 5'h00}, 1'b0);
    chk("meter_seek", 8'h01, 8'(met));
    send(4'h9, 8'h02, 1'b0);
    chk("meter_t9", 8'h00, 8'(met));
    idle();
    @(negedge clk) sdone = 1'b1;
    @(negedge clk) sdone = 1'b0;
    cyc(2);
    chk("meter_irq", 8'h01, 8'(met));
    @(negedge clk) seek = 1'b0;
    @(negedge clk) srch = 1'b1;
    @(negedge clk) srch = 1'b0;
    cyc(2);
    chk("meter_srch", 8'h01, 8'(met));
    @(negedge clk) rrdy = 1'b1;
    @(negedge clk) rrdy = 1'b0;
    cyc(2);
    chk("meter_rrdy", 8'h00, 8'(met));
  endtask : t_meter
  task automatic t_pwr;
    int n;
    n = 0;
    @(negedge clk) pup_n = 1'b0;
    while (pss !== 1'b1 && n < 4)
    begin
      cyc(1);
      n++;
    end
    chk("pwr_start", 8'h01, 8'(pss));
    if (pss === 1'b1)
    begin
      cyc(1);
      chk("pwr_pulse", 8'h00, 8'(pss));
    end
  endtask : t_pwr
  task automatic print_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    {rstn, go, bad, msg, grst, is200, onl, seek, srch, sdone, rrdy, resv} = '0;
    {cpwr, pup_n, tag, obus, lun, loc} = {2'b11, 18'h0};
    stat = 8'h5a;
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    t_tags();
    t_sel();
    t_resv();
    t_meter();
    t_pwr();
    print_verdict();
  end
endmodule : dtbi_tb_top
`default_nettype wire

// >>> core/dtbi_defines.svh
`ifndef DTBI_DEFINES_SVH
`define DTBI_DEFINES_SVH
// Operation
// - The drive takes four tag lines plus parity and decodes them into a tag function.
// - Tag values enter the decode only while tag gate is high.
// - The eight-bit outbound bus plus parity is read according to the active tag.
// - The drive is selected by module select gate with tag 3 and a valid logical address.
// - Selection needs outbound bits 7..5 under tag 3 to match the unit setting with odd parity, and lasts while module select gate is high.
// - General reset clears the reservation latches of a drive that is not selected.
// - A grounded power-up sequence line starts the power-on sequence.
// - While selected the drive returns its location on six lines in a 3-of-6 code.
// - The drive returns an eight-bit inbound bus plus parity whose meaning follows the tag; selected, the code returns status_i, bit 6 = is_200mb_i, for any tag.
// - Tag valid rises only after a gated tag with correct parity has been received.
// - Metering A is active while on line, seeking, and tag 9 outbound bit 1 not set since the last interrupt.
// - Metering A is also active during a record search until the first record-ready interrupt.
// - Inbound bit 6 active marks the unit as a 200 megabyte drive.

`define DTBI_TAG_SELECT    4'h3
`define DTBI_TAG_CONTROL   4'h9
`define DTBI_ADDR_MSB      7
`define DTBI_ADDR_LSB      5
`define DTBI_CTL_BIT_METER 1
`define DTBI_BI_BIT_200MB  6
`define DTBI_SEL_CODE_RST  6'h00
`endif

// >>> core/dtbi_pkg.sv
`default_nettype none
package dtbi_pkg;
  typedef enum logic [1:0] {DTBI_PWR_OFF, DTBI_PWR_SEQ, DTBI_PWR_ON} dtbi_pwr_t;
  typedef logic [2:0] dtbi_loc_t;
endpackage : dtbi_pkg
`default_nettype wire

// >>> core/dtbi_rx_if.sv
`timescale 1ns/10ps
`default_nettype none
interface dtbi_rx_if;
  logic [3:0] tag;
  logic       tag_ok;
  logic [7:0] bus_out;
  logic       bus_ok;
  modport src (output tag, tag_ok, bus_out, bus_ok);
  modport dst (input tag, tag_ok, bus_out, bus_ok);
endinterface : dtbi_rx_if
`default_nettype wire

// >>> core/dtbi_tag_rx.sv
`timescale 1ns/10ps
`default_nettype none
`include "dtbi_defines.svh"
module dtbi_tag_rx
  import dtbi_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       cop_en_i,
  input  wire logic [3:0] tag_bus_i,
  input  wire logic       tag_par_i,
  input  wire logic       tag_gate_i,
  input  wire logic [7:0] bus_out_i,
  input  wire logic       bus_out_par_i,
  dtbi_rx_if.src          rx
);
  logic [3:0] tag, next_tag;
  logic       tag_ok, next_tag_ok;
  logic [7:0] bus_out, next_bus_out;
  logic       bus_ok, next_bus_ok;

  always_comb
  begin
    next_tag     = tag;
    next_tag_ok  = 1'b0;
    next_bus_out = bus_out;
    next_bus_ok  = 1'b0;
    if (cop_en_i && tag_gate_i)
    begin
      // bad parity: tag not latched, no valid
      if (^{tag_bus_i, tag_par_i})
      begin
        next_tag    = tag_bus_i;
        next_tag_ok = 1'h1;
      end
    end
    if (cop_en_i)
    begin
      next_bus_out = bus_out_i;
      next_bus_ok  = ^{bus_out_i, bus_out_par_i};
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      tag     <= 4'h0;
      tag_ok  <= 1'b0;
      bus_out <= 8'h00;
      bus_ok  <= 1'b0;
    end
    else
    begin
      tag     <= next_tag;
      tag_ok  <= next_tag_ok;
      bus_out <= next_bus_out;
      bus_ok  <= next_bus_ok;
    end
  end

  assign rx.tag     = tag;
  assign rx.tag_ok  = tag_ok;
  assign rx.bus_out = bus_out;
  assign rx.bus_ok  = bus_ok;
endmodule : dtbi_tag_rx
`default_nettype wire

// >>> core/dtbi_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "dtbi_defines.svh"
module dtbi_top
  import dtbi_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rstn_i,
  input  wire logic [3:0] tag_bus_i,
  input  wire logic       tag_par_i,
  input  wire logic       tag_gate_i,
  input  wire logic [7:0] bus_out_i,
  input  wire logic       bus_out_par_i,
  input  wire logic       module_select_gate_i,
  input  wire logic       general_reset_i,
  input  wire logic       controller_power_present_i,
  input  wire logic       power_up_seq_n_i,
  input  wire logic [2:0] logical_unit_number_setting_i,
  input  wire logic [2:0] location_i,
  input  wire logic       is_200mb_i,
  input  wire logic [7:0] status_i,
  input  wire logic       on_line_i,
  input  wire logic       seek_busy_i,
  input  wire logic       search_start_i,
  input  wire logic       seek_done_irq_i,
  input  wire logic       record_ready_irq_i,
  input  wire logic       reserve_set_i,
  output logic            selected_o,
  output logic [5:0]      sel_code_o,
  output logic [7:0]      inbound_status_bus_o,
  output logic            inbound_par_o,
  output logic            tag_valid_o,
  output logic            metering_a_o,
  output logic            reserved_o,
  output logic            power_seq_start_o,
  output logic [3:0]      active_tag_o
);
  // ----------------------------------------
  // receivers
  // ----------------------------------------
  dtbi_rx_if rx ();

  dtbi_tag_rx u_rx (
    .ref_clk_i     (ref_clk_i),
    .rstn_i        (rstn_i),
    .cop_en_i      (controller_power_present_i),
    .tag_bus_i     (tag_bus_i),
    .tag_par_i     (tag_par_i),
    .tag_gate_i    (tag_gate_i),
    .bus_out_i     (bus_out_i),
    .bus_out_par_i (bus_out_par_i),
    .rx            (rx)
  );

  // ----------------------------------------
  // 3-of-6 location code
  // ----------------------------------------
  function automatic logic [5:0] loc_code(input dtbi_loc_t loc);
    logic [5:0] c;
    c = 6'h00;
    case (loc)
      3'h0: c = 6'h38;
      3'h1: c = 6'h31;
      3'h2: c = 6'h2a;
      3'h3: c = 6'h23;
      3'h4: c = 6'h1c;
      3'h5: c = 6'h15;
      3'h6: c = 6'h0e;
      default: c = 6'h07;
    endcase
    return c;
  endfunction : loc_code

  // ----------------------------------------
  // field checks
  // ----------------------------------------
  if (`DTBI_ADDR_MSB - `DTBI_ADDR_LSB + 1 != $bits(dtbi_loc_t))
  begin : g_addr_width
    $error("unit address field and unit setting differ in width");
  end

  // ----------------------------------------
  // tag capture
  // ----------------------------------------
  function automatic logic tag_is(input logic       ok,
                                  input logic [3:0] t,
                                  input logic [3:0] want);
    return ok && (t == want);
  endfunction : tag_is

  logic [3:0] atag, next_atag;
  logic       tv, next_tv;

  always_comb
  begin
    next_atag = atag;
    if (rx.tag_ok)
      next_atag = rx.tag;
    next_tv = rx.tag_ok;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      atag <= 4'h0;
      tv   <= 1'h0;
    end
    else
    begin
      atag <= next_atag;
      tv   <= next_tv;
    end
  end

  // ----------------------------------------
  // selection and location code
  // ----------------------------------------
  logic       sel, next_sel;
  logic [5:0] code, next_code;
  logic       addr_hit;

  always_comb
  begin
    addr_hit = rx.bus_ok &&
      (rx.bus_out[`DTBI_ADDR_MSB:`DTBI_ADDR_LSB] == logical_unit_number_setting_i);
    next_sel = sel;
    // select ends as soon as the gate or controller power goes
    if (!module_select_gate_i || !controller_power_present_i)
      next_sel = 1'h0;
    else if (tag_is(rx.tag_ok, rx.tag, `DTBI_TAG_SELECT) && addr_hit)
      next_sel = 1'h1;
    next_code = `DTBI_SEL_CODE_RST;
    if (next_sel)
      next_code = loc_code(location_i);
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      sel  <= 1'h0;
      code <= `DTBI_SEL_CODE_RST;
    end
    else
    begin
      sel  <= next_sel;
      code <= next_code;
    end
  end

  // ----------------------------------------
  // inbound status bus
  // ----------------------------------------
  logic [7:0] bi, next_bi;
  logic       bip, next_bip;

  always_comb
  begin
    next_bi = 8'h00;
    if (next_sel)
      next_bi = status_i;
    next_bi[`DTBI_BI_BIT_200MB] = next_sel && is_200mb_i;
    next_bip = ~^next_bi;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      bi  <= 8'h00;
      bip <= 1'h1;
    end
    else
    begin
      bi  <= next_bi;
      bip <= next_bip;
    end
  end

  // ----------------------------------------
  // reservation
  // ----------------------------------------
  logic rsv, next_rsv;

  always_comb
  begin
    next_rsv = rsv;
    // general reset spares the selected drive
    if (general_reset_i && controller_power_present_i && !sel)
      next_rsv = 1'h0;
    else if (sel && reserve_set_i)
      next_rsv = 1'h1;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      rsv <= 1'h0;
    end
    else
    begin
      rsv <= next_rsv;
    end
  end

  // ----------------------------------------
  // metering
  // ----------------------------------------
  logic ctl9, next_ctl9;
  logic search, next_search;
  logic meter, next_meter;
  logic irq;
  logic seek_meter;

  always_comb
  begin
    irq = seek_done_irq_i || record_ready_irq_i;
    next_ctl9 = ctl9;
    // an interrupt clear wins over a tag 9 in the same cycle
    if (irq)
      next_ctl9 = 1'h0;
    else if (sel && tag_is(rx.tag_ok, rx.tag, `DTBI_TAG_CONTROL) && rx.bus_ok &&
             rx.bus_out[`DTBI_CTL_BIT_METER])
      next_ctl9 = 1'h1;
    next_search = search;
    if (record_ready_irq_i)
      next_search = 1'h0;
    else if (search_start_i)
      next_search = 1'h1;
    seek_meter = on_line_i && seek_busy_i && !next_ctl9;
    next_meter = seek_meter || next_search;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      ctl9   <= 1'h0;
      search <= 1'h0;
      meter  <= 1'h0;
    end
    else
    begin
      ctl9   <= next_ctl9;
      search <= next_search;
      meter  <= next_meter;
    end
  end

  // ----------------------------------------
  // power sequence
  // ----------------------------------------
  dtbi_pwr_t pwr, next_pwr;
  logic      psq, next_psq;
  logic      pup_d, next_pup_d;

  always_comb
  begin
    next_pup_d = power_up_seq_n_i;
    next_psq = 1'h0;
    next_pwr = pwr;
    case (pwr)
      DTBI_PWR_OFF:
        // falling edge of the grounded line, once per power cycle
        if (!power_up_seq_n_i && pup_d)
        begin
          next_psq = 1'h1;
          next_pwr = DTBI_PWR_SEQ;
        end
      DTBI_PWR_SEQ:
        next_pwr = DTBI_PWR_ON;
      default:
        if (power_up_seq_n_i)
          next_pwr = DTBI_PWR_OFF;
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      psq   <= 1'h0;
      pup_d <= 1'h1;
      pwr   <= DTBI_PWR_OFF;
    end
    else
    begin
      psq   <= next_psq;
      pup_d <= next_pup_d;
      pwr   <= next_pwr;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign selected_o           = sel;
  assign sel_code_o           = code;
  assign inbound_status_bus_o = bi;
  assign inbound_par_o        = bip;
  assign tag_valid_o          = tv;
  assign metering_a_o         = meter;
  assign reserved_o           = rsv;
  assign power_seq_start_o    = psq;
  assign active_tag_o         = atag;
endmodule : dtbi_top
`default_nettype wire
